// ==== pkg/sdcr_defines.vh ====
// register offsets, reset values and field positions of the divider configuration bank
`ifndef SDCR_DEFINES_VH
`define SDCR_DEFINES_VH
`define SDCR_IDX_CFG_A      6'h1D
`define SDCR_IDX_CFG_B      6'h1E
`define SDCR_IDX_HALVER     6'h1F
`define SDCR_IDX_CFG_C      6'h20
`define SDCR_IDX_CFG_D      6'h21
`define SDCR_IDX_FB_UPPER   6'h22
`define SDCR_IDX_CFG_E      6'h23
`define SDCR_IDX_FB_LOWER   6'h24
`define SDCR_IDX_DLY        6'h25
`define SDCR_RST_CFG_A      16'h318C
`define SDCR_RST_CFG_B      16'h318C
`define SDCR_RST_HALVER     16'hC3EC
`define SDCR_RST_CFG_C      16'h0393
`define SDCR_RST_CFG_D      16'h1E21
`define SDCR_RST_FB_UPPER   16'h0010
`define SDCR_RST_CFG_E      16'h0004
`define SDCR_RST_FB_LOWER   16'h0070
`define SDCR_RST_DLY        16'h0205
`define SDCR_HALVER_BIT     14
`define SDCR_FB_UPPER_MSB   2
`define SDCR_DLY_MSB        13
`define SDCR_DLY_LSB        8
`define SDCR_RESP_OKAY      2'h0
`define SDCR_RESP_SLVERR    2'h2
`endif

// ==== hdl/sdcr_reg_cell.v ====
// one 16-bit configuration register with byte-lane writes
`timescale 1ns/1ps
module sdcr_reg_cell #(
  parameter [15:0] RESET_VAL = 16'h0000
) (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write side
  input  wire        wr_en,
  input  wire [1:0]  wr_strb,
  input  wire [15:0] wr_data,
  // stored value
  output reg  [15:0] value_r
);
  always @(posedge aclk) begin
    if (!aresetn) begin
      value_r <= RESET_VAL;
    end else if (wr_en) begin
      if (wr_strb[0]) begin
        value_r[7:0] <= wr_data[7:0];
      end
      if (wr_strb[1]) begin
        value_r[15:8] <= wr_data[15:8];
      end
    end
  end
endmodule

// ==== hdl/sdcr_regs.v ====
// divider configuration register bank behind an axi4-lite slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "sdcr_defines.vh"
// Operation
// - register 0x1F resets to 0xC3EC, halver enable and bit 15 set.
// - bit 14 of 0x1F enables the first divide-by-two stage.
// - feedback divide is 19 bits: 0x22 bits 2:0 over 0x24.
// - register 0x25 resets to 0x205, delay field 0x2 at 13:8.
module sdcr_regs (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // write address channel
  input  wire [7:0]  s_axi_awaddr,
  input  wire [2:0]  s_axi_awprot,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  // write data channel
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  // write response channel
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // read address channel
  input  wire [7:0]  s_axi_araddr,
  input  wire [2:0]  s_axi_arprot,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  // read data channel
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // configuration outputs
  output reg         first_halver_enable,
  output reg  [18:0] feedback_divide,
  output reg  [5:0]  detector_delay_select
);
  localparam NREG = 9;
  // slot code of an unmapped or unaligned address
  localparam [3:0] NO_SLOT = 4'h9;
  // slots of the cells that feed the configuration outputs
  localparam SLOT_HALVER   = 2;
  localparam SLOT_FB_UPPER = 5;
  localparam SLOT_FB_LOWER = 7;
  localparam SLOT_DLY      = 8;
  // reset images of the cells, slot 0 in the low half-word
  localparam [16*NREG-1:0] RESET_VALS = {
    `SDCR_RST_DLY,
    `SDCR_RST_FB_LOWER,
    `SDCR_RST_CFG_E,
    `SDCR_RST_FB_UPPER,
    `SDCR_RST_CFG_D,
    `SDCR_RST_CFG_C,
    `SDCR_RST_HALVER,
    `SDCR_RST_CFG_B,
    `SDCR_RST_CFG_A
  };
  localparam [15:0] RST_HALVER = `SDCR_RST_HALVER;
  localparam [15:0] RST_DLY    = `SDCR_RST_DLY;

  // maps a byte address to a register slot, NO_SLOT when unmapped
  function [3:0] slot_of;
    input [7:0] addr;
    reg   [5:0] idx;
    begin
      idx = addr[7:2];
      if (addr[1:0] != 2'h0 || idx < `SDCR_IDX_CFG_A || idx > `SDCR_IDX_DLY) begin
        slot_of = NO_SLOT;
      end else begin
        slot_of = idx[3:0] - 4'hD;
      end
    end
  endfunction

  // response code for a slot: error when nothing answers there
  function [1:0] resp_of;
    input [3:0] slot;
    begin
      if (slot == NO_SLOT) begin
        resp_of = `SDCR_RESP_SLVERR;
      end else begin
        resp_of = `SDCR_RESP_OKAY;
      end
    end
  endfunction

  reg         aw_held_r;
  reg  [7:0]  aw_addr_r;
  reg         w_held_r;
  reg  [15:0] w_data_r;
  reg  [1:0]  w_strb_r;
  wire        do_write;
  wire [3:0]  wr_slot;
  wire [3:0]  rd_slot;
  wire [15:0] cell_val [0:NREG-1];
  reg  [15:0] rd_val;

  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_slot  = slot_of(aw_addr_r);
  assign rd_slot  = slot_of(s_axi_araddr);

  // reserved cells reset to fixed values
  genvar g;
  generate
    for (g = 0; g < NREG; g = g + 1) begin : cells
      sdcr_reg_cell #(
        .RESET_VAL (RESET_VALS[16*g+15:16*g])
      ) u_cell (
        .aclk    (aclk),
        .aresetn (aresetn),
        .wr_en   (do_write && wr_slot == g),
        .wr_strb (w_strb_r),
        .wr_data (w_data_r),
        .value_r (cell_val[g])
      );
    end
  endgenerate

  // write address taken in either order, held until the response is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      aw_addr_r     <= 8'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end else if (s_axi_bvalid && s_axi_bready) begin
        aw_held_r <= 1'b0;
      end
    end
  end

  // write data taken in either order, held until the response is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r     <= 1'b0;
      w_data_r     <= 16'h0000;
      w_strb_r     <= 2'h0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[15:0];
        w_strb_r <= s_axi_wstrb[1:0];
      end else if (s_axi_bvalid && s_axi_bready) begin
        w_held_r <= 1'b0;
      end
    end
  end

  // response raised at commit, dropped when the master takes it
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `SDCR_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= resp_of(wr_slot);
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always @* begin
    rd_val = 16'h0000;
    if (rd_slot != NREG) begin
      rd_val = cell_val[rd_slot];
    end
  end

  // read address taken once, data held until the master takes it
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SDCR_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {16'h0000, rd_val};
        s_axi_rresp  <= resp_of(rd_slot);
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // configuration fields registered out
  always @(posedge aclk) begin
    if (!aresetn) begin
      first_halver_enable   <= RST_HALVER[`SDCR_HALVER_BIT];
      // divide resets to upper 0, lower 0x70
      feedback_divide       <= {3'h0, `SDCR_RST_FB_LOWER};
      detector_delay_select <= RST_DLY[`SDCR_DLY_MSB:`SDCR_DLY_LSB];
    end else begin
      first_halver_enable   <= cell_val[SLOT_HALVER][`SDCR_HALVER_BIT];
      feedback_divide       <= {cell_val[SLOT_FB_UPPER][`SDCR_FB_UPPER_MSB:0], cell_val[SLOT_FB_LOWER]};
      detector_delay_select <= cell_val[SLOT_DLY][`SDCR_DLY_MSB:`SDCR_DLY_LSB];
    end
  end
endmodule

// ==== testbench/sdcr_chk.sv ====
// port assertions for the divider configuration bank
`timescale 1ns/1ps
module sdcr_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus answers
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  // configuration outputs
  input wire logic        first_halver_enable,
  input wire logic [18:0] feedback_divide,
  input wire logic [5:0]  detector_delay_select
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rst; $rose(aresetn) |-> first_halver_enable && detector_delay_select == 6'h02; endproperty
  a_rst: assert property (p_rst) else $error("bad reset outputs");
  property p_halv;
    $changed(first_halver_enable) && $past(aresetn) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_halv: assert property (p_halv) else $error("enable moved without write");
  property p_div;
    $changed(feedback_divide) && $past(aresetn) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_div: assert property (p_div) else $error("divide moved without write");
  property p_dly;
    $changed(detector_delay_select) && $past(aresetn) |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2);
  endproperty
  a_dly: assert property (p_dly) else $error("delay moved without write");
  property p_rd; $rose(s_axi_rvalid) |-> $past(s_axi_arready); endproperty
  a_rd: assert property (p_rd) else $error("read answer without request");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  c_wr: cover property (s_axi_bvalid && s_axi_bresp == 2'h0);
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_halv: cover property ($fell(first_halver_enable));
endmodule
bind sdcr_regs sdcr_chk u_chk (.*);

// ==== testbench/tb.sv ====
// self-checking bench for the divider configuration bank
`timescale 1ns/1ps
module tb;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, first_halver_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]  s_axi_awprot, s_axi_arprot, t;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [18:0] feedback_divide;
  logic [5:0]  detector_delay_select;
  logic [15:0] rst_v [9] = '{16'h318C, 16'h318C, 16'hC3EC, 16'h0393, 16'h1E21, 16'h0010, 16'h0004, 16'h0070, 16'h0205};
  logic [31:0] wv [9] = '{32'h318C, 32'h318C, 32'h03EC, 32'h0393, 32'h1E21, 32'h0005, 32'h0004, 32'hFFFFABCD, 32'h8A04};
  int num_errors, n_compared, cyc, i;
  sdcr_regs dut (.*);
  initial begin
    aclk = 0;
    forever #5 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc >= 3000) begin num_errors++; close_out; end
  end
  task close_out;
    if (num_errors == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task cmp(input [31:0] g, e);
    n_compared++;
    if (g !== e) begin num_errors++; $display("[ERR] %0t got %h exp %h", $time, g, e); end
  endtask
  task wr(input [7:0] a, input [31:0] d, input [3:0] s);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= s;
    s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
    do begin
      @(negedge aclk); t = {s_axi_awready, s_axi_wready, s_axi_bvalid}; rs = s_axi_bresp;
      @(posedge aclk);
      if (t[2]) s_axi_awvalid <= 0;
      if (t[1]) s_axi_wvalid <= 0;
      if (t[0]) s_axi_bready <= 0;
    end while (!t[0]);
    @(posedge aclk);
  endtask
  task rdr(input [7:0] a);
    s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
    do begin
      @(negedge aclk); t = {s_axi_arready, 1'b0, s_axi_rvalid}; rd = s_axi_rdata; rs = s_axi_rresp;
      @(posedge aclk);
      if (t[2]) s_axi_arvalid <= 0;
      if (t[0]) s_axi_rready <= 0;
    end while (!t[0]);
    @(posedge aclk);
  endtask
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, s_axi_wstrb} = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    for (i = 0; i < 9; i++) begin rdr(8'h74 + 4 * i); cmp(rd, {16'h0, rst_v[i]}); end
    cmp({13'h0, feedback_divide}, 32'h70);
    // rows: host values written and read back
    for (i = 0; i < 9; i++) begin
      wr(8'h74 + 4 * i, wv[i], 4'hF);
      rdr(8'h74 + 4 * i);
      cmp(rd, {16'h0, wv[i][15:0]});
    end
    cmp({31'h0, first_halver_enable}, 32'h0);
    cmp({13'h0, feedback_divide}, 32'h5ABCD);
    cmp({26'h0, detector_delay_select}, 32'h0A);
    // byte lanes then halver back on
    wr(8'h7C, 32'hC0FF, 4'h1);
    rdr(8'h7C);
    cmp(rd, 32'h03FF);
    wr(8'h7C, 32'h4000, 4'h2);
    repeat (2) @(posedge aclk);
    cmp({31'h0, first_halver_enable}, 32'h1);
    // unmapped and unaligned places
    wr(8'h98, 32'h1234, 4'hF);
    cmp({30'h0, rs}, 32'h2);
    rdr(8'h75);
    cmp({rd[29:0], rs}, 32'h2);
    // reset in mid-run
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    cmp({12'h0, feedback_divide, first_halver_enable}, 32'hE1);
    rdr(8'h94);
    cmp(rd, 32'h0205);
    close_out;
  end
endmodule
